// file: verification/dsa_accumulator_asserts.sv
// Port-level checker for the accumulator datapath
module dsa_accumulator_asserts (
  input logic core_clk, // Core clock
  input logic reset, // Reset, active high
  input logic psel, // APB select
  input logic penable, // APB enable
  input logic pwrite, // APB direction
  input logic [11:0] paddr, // APB address
  input logic [31:0] pwdata, // APB write data
  input logic [31:0] prdata, // APB read data
  input logic pready, // APB ready
  input logic pslverr, // APB error
  input logic trapReq, // Trap pulse
  input logic xWriteValid, // X bus strobe
  input logic [15:0] xWriteAddr, // X bus address
  input logic [15:0] xWriteData // X bus data
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (reset);
  // --------------------------------------------
  // Bus handshake
  // --------------------------------------------
  a_ready_one_wait: assert property (psel && penable && !pready |=> pready)
    else $error("pready late after access phase");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held too long");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside ready cycle");
  a_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("prdata not zero outside ready");
  a_unmapped_error: assert property (psel && penable && !pready &&
    paddr > 12'h030 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  // --------------------------------------------
  // Status and events
  // --------------------------------------------
  a_status_or_bits: assert property (
    pready && !pwrite && !pslverr && paddr == 12'h004 |->
    prdata[4] == (prdata[0] | prdata[1]) &&
    prdata[5] == (prdata[2] | prdata[3]))
    else $error("combined status bits wrong");
  a_trap_pulse: assert property (trapReq |=> !trapReq)
    else $error("trap request longer than a pulse");
  a_xwrite_pulse: assert property (xWriteValid |=> !xWriteValid)
    else $error("X bus strobe longer than a pulse");
  cover property (trapReq);
  cover property (xWriteValid);
  cover property (pready && pslverr);
endmodule

bind dsa_accumulator dsa_accumulator_asserts chk (
  .core_clk(core_clk), .reset(reset), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .trapReq(trapReq),
  .xWriteValid(xWriteValid), .xWriteAddr(xWriteAddr),
  .xWriteData(xWriteData));

// file: verification/dsa_accumulator_tb.sv
// Self-checking bench for the accumulator datapath
module dsa_accumulator_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic core_clk, reset, psel, penable, pwrite, pready, pslverr, err;
  logic trapReq, xWriteValid;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] xWriteAddr, xWriteData, memAddr, memData;
  logic [39:0] accVal;
  int error_cnt = 0;
  int n_checks = 0;
  int cyc = 0;
  int trapCnt = 0;
  int i;
  typedef struct {logic [15:0] cfg; logic [39:0] acc;
    logic [11:0] cmd; logic [15:0] word;} dsa_row_t;
  // Store rows: config, accumulator, command, stored word
  dsa_row_t rows [10] = '{
    '{16'h0000, 40'h0012348000, 12'h020, 16'h1234},
    '{16'h0000, 40'h0012348000, 12'h060, 16'h1235},
    '{16'h0000, 40'h0012347fff, 12'h060, 16'h1234},
    '{16'h0004, 40'h0012348000, 12'h060, 16'h1234},
    '{16'h0004, 40'h0012358000, 12'h060, 16'h1236},
    '{16'h0004, 40'h0012348001, 12'h060, 16'h1235},
    '{16'h0008, 40'h0123450000, 12'h020, 16'h7fff},
    '{16'h0008, 40'hfe12340000, 12'h020, 16'h8000},
    '{16'h0000, 40'h0123450000, 12'h020, 16'h2345},
    '{16'h0008, 40'h007fff8000, 12'h060, 16'h7fff}};

  dsa_accumulator uut (.core_clk(core_clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .trapReq(trapReq), .xWriteValid(xWriteValid),
    .xWriteAddr(xWriteAddr), .xWriteData(xWriteData));
  dsa_xmem_model mem (.core_clk(core_clk), .reset(reset),
    .xWriteValid(xWriteValid), .xWriteAddr(xWriteAddr),
    .xWriteData(xWriteData), .lastAddr(memAddr), .lastData(memData));

  initial
  begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Count trap pulses and cut a hung run short
  always @(posedge core_clk)
  begin
    cyc++;
    if (trapReq === 1'b1)
      trapCnt++;
    if (cyc == 20000)
    begin
      error_cnt++;
      final_report;
    end
  end

  task automatic final_report;
    if (error_cnt == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input logic [39:0] got, input logic [39:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // One APB transfer, held until pready is seen, then one idle cycle
  task automatic apb(input logic w, input logic [11:0] a,
    input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do
      @(posedge core_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask
  task automatic setAcc(input logic b, input logic [39:0] v);
    wr(b ? 12'h018 : 12'h010, v[31:0]);
    wr(b ? 12'h01c : 12'h014, {24'h0, v[39:32]});
  endtask
  task automatic getAcc(input logic b);
    apb(1'b0, b ? 12'h018 : 12'h010, 32'h0);
    accVal[31:0] = rd;
    apb(1'b0, b ? 12'h01c : 12'h014, 32'h0);
    accVal[39:32] = rd[7:0];
  endtask
  // One adder operation, then accumulator and status compared
  task automatic arith(input logic clr, input logic [15:0] cfg,
    input logic [39:0] acc, input logic [31:0] opnd,
    input logic [11:0] cmd, input logic [39:0] expAcc,
    input logic [5:0] expSt);
    if (clr)
      wr(12'h004, 32'h0);
    wr(12'h000, {16'h0, cfg});
    setAcc(cmd[1], acc);
    wr(12'h008, opnd);
    wr(12'h00c, {20'h0, cmd});
    getAcc(cmd[1]);
    chk(accVal, expAcc);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd[5:0], expSt);
  endtask

  initial
  begin
    reset = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    apb(1'b0, 12'h004, 32'h0);
    chk(rd, 40'h0);
    wr(12'h024, 32'h100);
    for (i = 0; i < 10; i++)
    begin
      wr(12'h000, {16'h0, rows[i].cfg});
      setAcc(1'b0, rows[i].acc);
      wr(12'h00c, {20'h0, rows[i].cmd});
      apb(1'b0, 12'h020, 32'h0);
      chk(rd[15:0], rows[i].word);
      chk(memData, rows[i].word);
      getAcc(1'b0);
      chk(accVal, rows[i].acc);
    end
    arith(1, 16'h0090, 40'h7fffffffff, 1, 0, 40'h7fffffffff, 6'h35);
    arith(0, 16'h0090, 40'h0, 1, 0, 40'h1, 6'h24);
    arith(1, 16'h0080, 40'h00ffffffff, 1, 0, 40'h007fffffff, 6'h24);
    arith(1, 16'h0080, 40'hff80000000, 32'hffffffff, 0, 40'h0080000000,
      6'h24);
    arith(1, 16'h0100, 40'h00ffffffff, 1, 0, 40'h0100000000, 6'h11);
    chk(trapCnt, 1);
    arith(1, 16'h0400, 40'h7fffffffff, 1, 0, 40'h8000000000, 6'h35);
    chk(trapCnt, 2);
    arith(1, 16'h0000, 40'h5, 3, 12'h083, 40'h2, 6'h11);
    arith(1, 16'h0000, 40'h5, 3, 12'h001, 40'h1, 6'h00);
    arith(1, 16'h0000, 40'h007fffffff, 1, 0, 40'h0080000000, 6'h00);
    setAcc(1'b1, 40'h0012348000);
    wr(12'h024, 32'h100);
    wr(12'h00c, 32'h018);
    repeat (2) @(posedge core_clk);
    chk(memAddr, 40'h100);
    chk(memData, 40'h1235);
    apb(1'b0, 12'h024, 32'h0);
    chk(rd[15:0], 40'h102);
    wr(12'h00c, 32'h008);
    apb(1'b0, 12'h024, 32'h0);
    chk(rd[15:0], 40'h1235);
    setAcc(1'b0, 40'h0012345678);
    wr(12'h028, 32'h4);
    wr(12'h00c, 32'h900);
    apb(1'b0, 12'h02c, 32'h0);
    chk(rd, 40'h01234567);
    wr(12'h028, 32'h3c);
    wr(12'h00c, 32'h900);
    apb(1'b0, 12'h02c, 32'h0);
    chk(rd, 40'h23456780);
    apb(1'b0, 12'h030, 32'h0);
    chk(rd[7:0], 40'h01);
    wr(12'h008, 32'h1234);
    wr(12'h00c, 32'h800);
    apb(1'b0, 12'h02c, 32'h0);
    chk(rd, 40'h00012340);
    wr(12'h028, 32'h4);
    wr(12'h00c, 32'h800);
    apb(1'b0, 12'h02c, 32'h0);
    chk(rd, 40'h01234000);
    apb(1'b0, 12'h040, 32'h0);
    chk({err, rd}, {8'h1, 32'h0});
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    reset <= 1'b0;
    @(posedge core_clk);
    getAcc(1'b0);
    chk(accVal, 40'h0);
    final_report;
  end
endmodule

// file: verification/dsa_xmem_model.sv
// X bus data memory model that captures core writes
module dsa_xmem_model (
  input logic core_clk, // Core clock
  input logic reset, // Reset, active high
  input logic xWriteValid, // Write strobe
  input logic [15:0] xWriteAddr, // Write address
  input logic [15:0] xWriteData, // Write data
  output logic [15:0] lastAddr, // Last address written
  output logic [15:0] lastData // Last word written
);
  timeunit 1ns;
  timeprecision 1ns;
  // Take a word only on the strobe; the bus means nothing between
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      lastAddr <= 16'h0000;
      lastData <= 16'h0000;
    end
    else if (xWriteValid)
    begin
      lastAddr <= xWriteAddr;
      lastData <= xWriteData;
    end
  end
endmodule

// file: verilog/dsa_accumulator.v
// DSP accumulator datapath with APB register access
//
// Functional notes
// RULE_01: 40-bit adder, subtract complements, borrow active-low
// RULE_02: Guard overflow flag reflects latest operation
// RULE_03: Guard or catastrophic flags request warning trap
// RULE_04: Sticky saturation flags cleared only by software
// RULE_05: Saturation off: sticky flag from bit 39
// RULE_06: Status ORs both overflow and saturation flags
// RULE_07: Saturation uses result, flags, enables, mode
// RULE_08: 40-bit mode loads 9.31 extremes, sets sticky
// RULE_09: 32-bit mode loads 1.31 extremes, sets sticky
// RULE_10: 32-bit mode never sets guard overflow
// RULE_11: Catastrophic mode sets sticky, accumulator wraps
// RULE_12: Write-back rounds high word of other accumulator
// RULE_13: Write-back direct or indirect with pointer plus two
// RULE_14: Round block yields 1.15, truncates unless rounding
// RULE_15: Conventional rounding adds bit 15
// RULE_16: Convergent rounding ties use bit 16
// RULE_17: Store truncated or rounded; write-back always rounded
// RULE_18: Write saturation clamps high to 0x7FFF
// RULE_19: Write saturation clamps low, sign bit 39
// RULE_20: Write saturation off passes value unchanged
// RULE_21: Signed shift amount, one cycle, up to 16
// RULE_22: 40-bit shifter, X operand placement by direction
// RULE_23: Configuration bits select all engine options; bits 0 and 1 (IF, US) drive no logic
// RULE_24: Mode bit one selects 40-bit saturation
`include "dsa_defines.vh"
module dsa_accumulator (
  input wire core_clk, // 50 MHz core clock
  input wire reset, // Asynchronous reset, active high
  input wire psel, // APB select
  input wire penable, // APB enable
  input wire pwrite, // APB direction
  input wire [11:0] paddr, // APB byte address
  input wire [31:0] pwdata, // APB write data
  output reg [31:0] prdata, // APB read data
  output reg pready, // APB ready
  output reg pslverr, // APB error
  output reg trapReq, // Arithmetic warning trap pulse
  output reg xWriteValid, // X bus write strobe pulse
  output reg [15:0] xWriteAddr, // X bus write address
  output reg [15:0] xWriteData // X bus write data
);
  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  reg [15:0] coreConfig_q;
  reg [39:0] accA_q;
  reg [39:0] accB_q;
  reg [39:0] operand_q;
  reg [39:0] shiftRes_q;
  reg [5:0] shiftAmt_q;
  reg [15:0] wbPtr_q;
  reg [15:0] storeWord_q;
  reg accAGuardOvf_q;
  reg accBGuardOvf_q;
  reg accAStickySat_q;
  reg accBStickySat_q;
  reg opPending_q;
  reg [11:0] cmd_q;
  // ------------------------------------------------------------
  // Bus decode
  // ------------------------------------------------------------
  wire busWrite;
  wire busRead;
  wire addrOk;
  wire accessDone;
  // A write lands only at the edge where pready is seen high, so a
  // held request is applied once and a command never runs twice
  assign accessDone = psel && penable && pready;
  assign busWrite = accessDone && pwrite;
  assign busRead = psel && penable && !pwrite;
  assign addrOk = (paddr[1:0] == 2'b00) && (paddr <= `DSA_SHHI_ADDR);
  // ------------------------------------------------------------
  // Adder and saturation
  // ------------------------------------------------------------
  wire useB;
  wire [39:0] target;
  wire [39:0] other;
  wire [39:0] lhs;
  wire [39:0] rhs;
  wire cin;
  wire [40:0] sum;
  wire [39:0] raw;
  wire ovf39;
  wire ovf31;
  wire guardOvf;
  wire satEn;
  wire mode40;
  reg [39:0] satRes;
  reg satHit;
  assign useB = cmd_q[`DSA_CMD_ACCB];
  assign target = useB ? accB_q : accA_q;
  assign other = useB ? accA_q : accB_q;
  // Optional zero input on the accumulator side
  assign lhs = cmd_q[`DSA_CMD_ZERO] ? 40'h0000000000 : target;
  // Subtract complements operand; carry doubles as active-low borrow
  assign rhs = cmd_q[`DSA_CMD_SUB] ? ~operand_q : operand_q; // RULE_01
  assign cin = cmd_q[`DSA_CMD_CIN]; // RULE_01
  assign sum = {1'b0, lhs} + {1'b0, rhs} + {40'h0000000000, cin};
  assign raw = sum[39:0];
  // Signed overflow out of bit 39
  assign ovf39 = (lhs[39] == rhs[39]) && (raw[39] != lhs[39]);
  // Value no longer fits 1.31
  assign ovf31 = !ovf39 && (raw[39:31] != {9{raw[39]}});
  // Guard bits that disagree among themselves mark a guard overflow
  assign guardOvf = raw[39:32] != {8{raw[39]}}; // RULE_02
  assign satEn = useB ? coreConfig_q[`DSA_CFG_ACC_B_SAT_ENABLE]
                      : coreConfig_q[`DSA_CFG_ACC_A_SAT_ENABLE]; // RULE_07 RULE_23
  assign mode40 = coreConfig_q[`DSA_CFG_ACC_SAT_MODE_SELECT]; // RULE_24
  // Choose saturation value by mode
  always @*
  begin
    satRes = raw;
    satHit = 1'b0;
    if (!satEn)
      satHit = ovf39; // RULE_05 RULE_11
    else if (mode40)
    begin
      if (ovf39) // RULE_08
      begin
        satHit = 1'b1;
        satRes = lhs[39] ? `DSA_MIN40 : `DSA_MAX40;
      end
    end
    else if (ovf39 || ovf31) // RULE_09
    begin
      satHit = 1'b1;
      satRes = (ovf39 ? lhs[39] : raw[39]) ? `DSA_MIN32 : `DSA_MAX32;
    end
  end
  // ------------------------------------------------------------
  // Round, write saturation and shifter
  // ------------------------------------------------------------
  wire [15:0] wbWord;
  wire [15:0] storeWord;
  wire [39:0] shiftIn;
  wire [39:0] shiftOut;
  wire [39:0] xPlaced;
  // Write-back always rounds the non-target accumulator
  dsa_round_sat wbRound (
    .accVal(other), // RULE_12
    .doRound(1'b1), // RULE_17
    .convergent(coreConfig_q[`DSA_CFG_RND]),
    .satEnable(coreConfig_q[`DSA_CFG_DATA_WRITE_SAT_ENABLE]),
    .wordOut(wbWord)
  );
  // Store truncates or rounds the target as asked
  dsa_round_sat storeRound (
    .accVal(target),
    .doRound(cmd_q[`DSA_CMD_RND]), // RULE_17
    .convergent(coreConfig_q[`DSA_CFG_RND]),
    .satEnable(coreConfig_q[`DSA_CFG_DATA_WRITE_SAT_ENABLE]),
    .wordOut(storeWord)
  );
  // X operand sits high for right shifts, low for left
  assign xPlaced = shiftAmt_q[5]
    ? {24'h000000, operand_q[15:0]}
    : {{8{operand_q[15]}}, operand_q[15:0], 16'h0000}; // RULE_22
  assign shiftIn = cmd_q[`DSA_CMD_SHACC] ? target : xPlaced;
  dsa_shifter #(.W(40)) shifter (
    .operand(shiftIn),
    .amount(shiftAmt_q), // RULE_21
    .logical(cmd_q[`DSA_CMD_LOGIC]),
    .result(shiftOut)
  );
  // ------------------------------------------------------------
  // Operation execution and register writes
  // ------------------------------------------------------------
  wire doAdd;
  wire doShift;
  wire doWb;
  wire doStore;
  wire clrSa;
  wire clrSb;
  wire setOa;
  wire setOb;
  assign doAdd = opPending_q && !cmd_q[`DSA_CMD_SHIFT]
    && !cmd_q[`DSA_CMD_STORE];
  assign doShift = opPending_q && cmd_q[`DSA_CMD_SHIFT];
  assign doStore = opPending_q && cmd_q[`DSA_CMD_STORE];
  assign doWb = doAdd && cmd_q[`DSA_CMD_WB]; // RULE_12
  // Writing zero to a sticky bit clears it; writing one leaves it
  assign clrSa = busWrite && paddr == `DSA_STAT_ADDR
    && !pwdata[`DSA_ST_SA]; // RULE_04
  assign clrSb = busWrite && paddr == `DSA_STAT_ADDR
    && !pwdata[`DSA_ST_SB]; // RULE_04
  // Guard overflow is held off while 32-bit saturation is in force
  assign setOa = doAdd && !useB && guardOvf && !(satEn && !mode40); // RULE_10
  assign setOb = doAdd && useB && guardOvf && !(satEn && !mode40); // RULE_10
  // Accumulators, flags and commands
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      coreConfig_q <= `DSA_CFG_RESET;
      accA_q <= 40'h0000000000;
      accB_q <= 40'h0000000000;
      operand_q <= 40'h0000000000;
      shiftRes_q <= 40'h0000000000;
      shiftAmt_q <= 6'h00;
      wbPtr_q <= 16'h0000;
      storeWord_q <= 16'h0000;
      accAGuardOvf_q <= 1'b0;
      accBGuardOvf_q <= 1'b0;
      accAStickySat_q <= 1'b0;
      accBStickySat_q <= 1'b0;
      opPending_q <= 1'b0;
      cmd_q <= 12'h000;
      trapReq <= 1'b0;
      xWriteValid <= 1'b0;
      xWriteAddr <= 16'h0000;
      xWriteData <= 16'h0000;
    end
    else
    begin
      opPending_q <= 1'b0;
      trapReq <= 1'b0;
      xWriteValid <= 1'b0;
      if (busWrite)
      begin
        case (paddr)
          `DSA_CFG_ADDR: coreConfig_q <= pwdata[15:0]; // RULE_23
          `DSA_OPND_ADDR: operand_q <= {{8{pwdata[31]}}, pwdata};
          `DSA_CMD_ADDR:
          begin
            cmd_q <= pwdata[11:0];
            opPending_q <= 1'b1;
          end
          `DSA_ACCA_LO_ADDR: accA_q[31:0] <= pwdata;
          `DSA_ACCA_HI_ADDR: accA_q[39:32] <= pwdata[7:0];
          `DSA_ACCB_LO_ADDR: accB_q[31:0] <= pwdata;
          `DSA_ACCB_HI_ADDR: accB_q[39:32] <= pwdata[7:0];
          `DSA_PTR_ADDR: wbPtr_q <= pwdata[15:0];
          `DSA_SHIFT_ADDR: shiftAmt_q <= pwdata[5:0];
          default: ;
        endcase
      end
      // Sticky flags: hardware set beats software clear
      if (doAdd && !useB && satHit)
        accAStickySat_q <= 1'b1; // RULE_04
      else if (clrSa)
        accAStickySat_q <= 1'b0;
      if (doAdd && useB && satHit)
        accBStickySat_q <= 1'b1; // RULE_04
      else if (clrSb)
        accBStickySat_q <= 1'b0;
      if (doAdd)
      begin
        if (useB)
        begin
          accB_q <= satRes; // RULE_08 RULE_09 RULE_11
          accBGuardOvf_q <= setOb; // RULE_02
        end
        else
        begin
          accA_q <= satRes;
          accAGuardOvf_q <= setOa; // RULE_02
        end
        // One trap pulse per adder operation at most
        trapReq <= (setOa && coreConfig_q[`DSA_CFG_ACC_A_OVERFLOW_TRAP_ENABLE])
          || (setOb && coreConfig_q[`DSA_CFG_ACC_B_OVERFLOW_TRAP_ENABLE])
          || (!satEn && satHit && coreConfig_q[`DSA_CFG_CATASTROPHIC_TRAP_ENABLE]); // RULE_03
      end
      // Direct mode replaces the pointer; indirect posts, then steps it
      if (doWb) // RULE_13
      begin
        if (cmd_q[`DSA_CMD_WBIND])
        begin
          xWriteValid <= 1'b1;
          xWriteAddr <= wbPtr_q;
          xWriteData <= wbWord;
          wbPtr_q <= wbPtr_q + `DSA_PTR_STEP;
        end
        else
          wbPtr_q <= wbWord;
      end
      if (doStore)
      begin
        storeWord_q <= storeWord;
        xWriteValid <= 1'b1;
        xWriteAddr <= wbPtr_q;
        xWriteData <= storeWord;
      end
      if (doShift)
      begin
        if (cmd_q[`DSA_CMD_SHSEL] && useB)
          accB_q <= shiftOut;
        else if (cmd_q[`DSA_CMD_SHSEL])
          accA_q <= shiftOut;
        shiftRes_q <= shiftOut;
      end
    end
  end
  // ------------------------------------------------------------
  // APB read and answer
  // ------------------------------------------------------------
  reg [31:0] rdMux;
  // Read data selection
  always @*
  begin
    rdMux = 32'h00000000;
    case (paddr)
      `DSA_CFG_ADDR: rdMux = {16'h0000, coreConfig_q};
      `DSA_STAT_ADDR: rdMux = {26'h0000000,
        accAStickySat_q | accBStickySat_q,
        accAGuardOvf_q | accBGuardOvf_q,
        accBStickySat_q, accAStickySat_q,
        accBGuardOvf_q, accAGuardOvf_q}; // RULE_06
      `DSA_OPND_ADDR: rdMux = operand_q[31:0];
      `DSA_CMD_ADDR: rdMux = {20'h00000, cmd_q};
      `DSA_ACCA_LO_ADDR: rdMux = accA_q[31:0];
      `DSA_ACCA_HI_ADDR: rdMux = {24'h000000, accA_q[39:32]};
      `DSA_ACCB_LO_ADDR: rdMux = accB_q[31:0];
      `DSA_ACCB_HI_ADDR: rdMux = {24'h000000, accB_q[39:32]};
      `DSA_WDATA_ADDR: rdMux = {16'h0000, storeWord_q};
      `DSA_PTR_ADDR: rdMux = {16'h0000, wbPtr_q};
      `DSA_SHIFT_ADDR: rdMux = {26'h0000000, shiftAmt_q};
      `DSA_SHLO_ADDR: rdMux = shiftRes_q[31:0];
      `DSA_SHHI_ADDR: rdMux = {24'h000000, shiftRes_q[39:32]};
      default: rdMux = 32'h00000000;
    endcase
  end
  // One wait state: pready rises the cycle after penable
  always @(posedge core_clk or posedge reset)
  begin
    if (reset)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end
    else
    begin
      pready <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !addrOk;
      prdata <= (busRead && !pready) ? rdMux : 32'h00000000;
    end
  end
endmodule

// file: verilog/dsa_defines.vh
// Constants for the DSP accumulator datapath
`ifndef DSA_DEFINES_VH
`define DSA_DEFINES_VH
// APB register byte addresses
`define DSA_CFG_ADDR 12'h000
`define DSA_STAT_ADDR 12'h004
`define DSA_OPND_ADDR 12'h008
`define DSA_CMD_ADDR 12'h00c
`define DSA_ACCA_LO_ADDR 12'h010
`define DSA_ACCA_HI_ADDR 12'h014
`define DSA_ACCB_LO_ADDR 12'h018
`define DSA_ACCB_HI_ADDR 12'h01c
`define DSA_WDATA_ADDR 12'h020
`define DSA_PTR_ADDR 12'h024
`define DSA_SHIFT_ADDR 12'h028
`define DSA_SHLO_ADDR 12'h02c
`define DSA_SHHI_ADDR 12'h030
// Configuration word field positions
`define DSA_CFG_IF 0
`define DSA_CFG_US 1
`define DSA_CFG_RND 2
`define DSA_CFG_DATA_WRITE_SAT_ENABLE 3
`define DSA_CFG_ACC_SAT_MODE_SELECT 4
`define DSA_CFG_ACC_B_SAT_ENABLE 6
`define DSA_CFG_ACC_A_SAT_ENABLE 7
`define DSA_CFG_ACC_A_OVERFLOW_TRAP_ENABLE 8
`define DSA_CFG_ACC_B_OVERFLOW_TRAP_ENABLE 9
`define DSA_CFG_CATASTROPHIC_TRAP_ENABLE 10
`define DSA_CFG_RESET 16'h0000
// Status word field positions
`define DSA_ST_OA 0
`define DSA_ST_OB 1
`define DSA_ST_SA 2
`define DSA_ST_SB 3
`define DSA_ST_OAB 4
`define DSA_ST_SAB 5
// Command field positions
`define DSA_CMD_SUB 0
`define DSA_CMD_ACCB 1
`define DSA_CMD_ZERO 2
`define DSA_CMD_WB 3
`define DSA_CMD_WBIND 4
`define DSA_CMD_STORE 5
`define DSA_CMD_RND 6
`define DSA_CMD_CIN 7
`define DSA_CMD_SHACC 8
`define DSA_CMD_SHSEL 9
`define DSA_CMD_LOGIC 10
`define DSA_CMD_SHIFT 11
// Saturation values
`define DSA_MAX40 40'h7fffffffff
`define DSA_MIN40 40'h8000000000
`define DSA_MAX32 40'h007fffffff
`define DSA_MIN32 40'h0080000000
`define DSA_MAXW 16'h7fff
`define DSA_MINW 16'h8000
`define DSA_PTR_STEP 16'h0002
`endif

// file: verilog/dsa_round_sat.v
// Round logic and data space write saturation
`include "dsa_defines.vh"
module dsa_round_sat (
  input wire [39:0] accVal, // Source accumulator
  input wire doRound, // Round requested
  input wire convergent, // Convergent rounding mode
  input wire satEnable, // Data write saturation on
  output reg [15:0] wordOut // 1.15 word for data space
);
  reg incr;
  reg [24:0] wide;
  // Round then saturate against the accumulator sign
  always @*
  begin
    incr = 1'b0;
    if (doRound) // RULE_14
    begin
      incr = accVal[15]; // RULE_15
      if (convergent && accVal[15:0] == 16'h8000) // RULE_16
        incr = accVal[16];
    end
    wide = accVal[39:15] + {24'h000000, incr};
    wordOut = wide[16:1];
    if (satEnable)
    begin
      if (!accVal[39] && wide[24:16] != 9'h000) // RULE_18
        wordOut = `DSA_MAXW;
      else if (accVal[39] && wide[24:16] != 9'h1ff) // RULE_19
        wordOut = `DSA_MINW;
    end // RULE_20 otherwise passes unmodified
  end
endmodule

// file: verilog/dsa_shifter.v
// 40-bit signed-amount barrel shifter
module dsa_shifter #(
  parameter W = 40
) (
  input wire [W-1:0] operand, // Value to shift
  input wire signed [5:0] amount, // Positive right, negative left
  input wire logical, // Logical right shift
  output reg [W-1:0] result // Shifted value
);
  reg [4:0] mag;
  reg signed [5:0] negAmt;
  // One-cycle shift by up to 16 in either direction
  always @*
  begin
    mag = 5'h00;
    negAmt = -amount;
    result = operand;
    if (amount > 6'sd0) // RULE_21
    begin
      mag = (amount > 6'sd16) ? 5'h10 : amount[4:0];
      if (logical)
        result = operand >> mag;
      else
        result = $signed(operand) >>> mag;
    end
    else if (amount < 6'sd0)
    begin
      mag = (amount < -6'sd16) ? 5'h10 : negAmt[4:0];
      result = operand << mag;
    end
  end
endmodule
